//--- hw/dtsc_defs.vh
// Purpose: constants shared by the debug trigger and status logic
// Assumes: included by bare name from the design files
// Notes:   offsets are byte addresses on the apb bus
`ifndef DTSC_DEFS_VH
`define DTSC_DEFS_VH

// register byte offsets
`define DTSC_OFF_CTRL      12'h000
`define DTSC_OFF_TRIG      12'h004
`define DTSC_OFF_STAT      12'h008
`define DTSC_OFF_FIFO      12'h00c

// control register fields
`define DTSC_CTRL_EN_BIT   7
`define DTSC_CTRL_ARM_BIT  6

// trigger configuration fields
`define DTSC_TRIG_OPQ_BIT  7
`define DTSC_TRIG_BEG_BIT  6
`define DTSC_TRIG_MODE_HI  3

// status fields
`define DTSC_STAT_AF_BIT   7
`define DTSC_STAT_BF_BIT   6
`define DTSC_STAT_ARM_BIT  5

// reset values
`define DTSC_CTRL_RST      8'h00
`define DTSC_TRIG_RST      8'h00
`define DTSC_CNT_RST       4'h0

// trigger mode codes
`define DTSC_MODE_A        4'h0
`define DTSC_MODE_A_OR_B   4'h1
`define DTSC_MODE_A_THEN_B 4'h2
`define DTSC_MODE_EV_B     4'h3
`define DTSC_MODE_A_EV_B   4'h4
`define DTSC_MODE_A_AND_D  4'h5
`define DTSC_MODE_A_NOT_D  4'h6
`define DTSC_MODE_INSIDE   4'h7
`define DTSC_MODE_OUTSIDE  4'h8

// trace storage depth and the count one short of full
`define DTSC_FIFO_WORDS    4'h8
`define DTSC_FIFO_LAST     4'h7

`endif

//--- hw/dtsc_trace_mem.v
// Purpose: small trace word store, one write port and one registered read port
// Assumes: single clock, read address is presented one cycle ahead
// Notes:   array has no reset; only the read register does
module dtsc_trace_mem #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clock,
  input  wire             resetn,
  // write port
  input  wire             wrEn,
  input  wire [AW-1:0]    wrAddr,
  input  wire [WIDTH-1:0] wrData,
  // read port
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];

  // write words as they are captured
  always @(posedge clock) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  // read data always comes out of a register
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdData <= {WIDTH{1'b0}};
    end else begin
      rdData <= store[rdAddr];
    end
  end

endmodule

//--- hw/dtsc_trigger_status.v
// Purpose: trigger selection, run control and status of the debug trace block
// Assumes: cpu bus and comparator inputs are on clock; secure is asynchronous
// Notes:   apb slave, zero wait in access phase, unmapped addresses answer pslverr
`include "dtsc_defs.vh"

module dtsc_trigger_status #(
  parameter FIFO_AW = 3
) (
  // clock and reset
  input  wire        clock,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // cpu bus and comparator results
  input  wire        busCycle,
  input  wire [15:0] busAddr,
  input  wire [7:0]  busData,
  input  wire        cmpAMatch,
  input  wire        cmpBMatch,
  input  wire        cmpBDataMatch,
  input  wire        addrGeA,
  input  wire        addrLeB,
  input  wire        opcodeFetch,
  input  wire        opcodeExecute,
  // device security level
  input  wire        secure
);

  // trigger mode decode, used for the live trigger
  function trigDecode;
    input [3:0] mode;
    input       aHit;
    input       bHit;
    input       seqA;
    input       dataB;
    input       cyc;
    input       inRange;
    begin
      case (mode)
        `DTSC_MODE_A:        trigDecode = aHit;
        `DTSC_MODE_A_OR_B:   trigDecode = aHit | bHit;
        `DTSC_MODE_A_THEN_B: trigDecode = seqA & bHit;
        `DTSC_MODE_EV_B:     trigDecode = bHit;
        `DTSC_MODE_A_EV_B:   trigDecode = aHit;
        `DTSC_MODE_A_AND_D:  trigDecode = aHit & dataB;
        `DTSC_MODE_A_NOT_D:  trigDecode = aHit & ~dataB;
        `DTSC_MODE_INSIDE:   trigDecode = cyc & inRange;
        `DTSC_MODE_OUTSIDE:  trigDecode = cyc & ~inRange;
        default:             trigDecode = 1'b0;
      endcase
    end
  endfunction

  // address decode, used for mapping and for the fifo advance
  function isAddr;
    input [11:0] a;
    input [11:0] off;
    begin
      isAddr = (a == off);
    end
  endfunction

  // state, and the reset images of the control and trigger registers
  localparam [7:0] CTRL_RST = `DTSC_CTRL_RST, TRIG_RST = `DTSC_TRIG_RST;
  reg               secureMeta_reg;
  reg               secure_reg;
  reg               enable_reg;
  reg               arm_reg;
  reg               opqSel_reg;
  reg               beginSel_reg;
  reg  [3:0]        mode_reg;
  reg               aFlag_reg;
  reg               bFlag_reg;
  reg  [3:0]        count_reg;
  reg  [FIFO_AW-1:0] wrPtr_reg;
  reg  [FIFO_AW-1:0] rdPtr_reg;
  reg  [FIFO_AW-1:0] rdPtr_next;
  reg               storing_reg;
  reg               seqA_reg;
  reg               tagPending_reg;
  reg  [31:0]       rdMux;

  wire [15:0]       memRdData;
  wire              setupPhase;
  wire              accessEdge;
  wire              wrAcc;
  wire              rdAcc;
  wire              mapped;
  wire              ctrlWr;
  wire              wrEnable;
  wire              startRun;
  wire              stopRun;
  wire              eventOnly;
  wire              beginTrace;
  wire              aHit;
  wire              bHit;
  wire              rawTrig;
  wire              qualTrig;
  wire              trigNow;
  wire              storeEvent;
  wire              storeNow;
  wire              fullAfter;
  wire              runDone;
  wire [15:0]       storeWord;
  wire [FIFO_AW-1:0] wrPtrInc;
  wire              fifoAdvance;

  // apb phase decode
  assign setupPhase = psel & ~penable;
  assign accessEdge = psel & penable & pready;
  assign wrAcc      = accessEdge & pwrite;
  assign rdAcc      = accessEdge & ~pwrite;
  assign mapped     = isAddr(paddr, `DTSC_OFF_CTRL) | isAddr(paddr, `DTSC_OFF_TRIG) |
                      isAddr(paddr, `DTSC_OFF_STAT) | isAddr(paddr, `DTSC_OFF_FIFO);
  // control writes: enable gated by security, arm gated by enable
  assign ctrlWr   = wrAcc & isAddr(paddr, `DTSC_OFF_CTRL);
  assign wrEnable = pwdata[`DTSC_CTRL_EN_BIT] & ~secure_reg;
  assign startRun = ctrlWr & wrEnable & pwdata[`DTSC_CTRL_ARM_BIT] & ~arm_reg;
  assign stopRun  = ctrlWr & (~pwdata[`DTSC_CTRL_ARM_BIT] | ~wrEnable);
  // run flavour
  assign eventOnly  = (mode_reg == `DTSC_MODE_EV_B) | (mode_reg == `DTSC_MODE_A_EV_B);
  assign beginTrace = eventOnly | beginSel_reg;
  // comparator hits and trigger selection
  assign aHit    = busCycle & cmpAMatch;
  assign bHit    = busCycle & cmpBMatch;
  assign rawTrig = trigDecode(mode_reg, aHit, bHit, seqA_reg, cmpBDataMatch,
                              busCycle, addrGeA & addrLeB);
  assign qualTrig = opqSel_reg ? (tagPending_reg & opcodeExecute) : rawTrig;
  assign trigNow  = arm_reg & qualTrig;
  // capture: event modes store b data bytes, others store fetch addresses
  assign storeEvent = eventOnly ? bHit : opcodeFetch;
  assign storeNow   = arm_reg & storeEvent & (~beginTrace | storing_reg | trigNow);
  assign storeWord  = eventOnly ? {8'h00, busData} : busAddr;
  assign wrPtrInc   = wrPtr_reg + {{(FIFO_AW-1){1'b0}}, 1'b1};
  // completion: begin trace on full, end trace on trigger
  assign fullAfter = (count_reg == `DTSC_FIFO_WORDS) |
                     (storeNow & (count_reg == `DTSC_FIFO_LAST));
  assign runDone   = arm_reg & (beginTrace ? (storeNow & (count_reg == `DTSC_FIFO_LAST))
                                           : trigNow);
  // fifo reads advance only while not armed
  assign fifoAdvance = rdAcc & isAddr(paddr, `DTSC_OFF_FIFO) & ~arm_reg;
  // read pointer next value feeds the memory so read data track it
  always @* begin
    rdPtr_next = rdPtr_reg;
    if (runDone) begin
      rdPtr_next = fullAfter ? (storeNow ? wrPtrInc : wrPtr_reg) : {FIFO_AW{1'b0}};
    end else if (startRun) begin
      rdPtr_next = {FIFO_AW{1'b0}};
    end else if (fifoAdvance) begin
      rdPtr_next = rdPtr_reg + {{(FIFO_AW-1){1'b0}}, 1'b1};
    end
  end

  // read data mux
  always @* begin
    rdMux = 32'h0000_0000;
    if (isAddr(paddr, `DTSC_OFF_CTRL)) begin
      rdMux[`DTSC_CTRL_EN_BIT]  = enable_reg;
      rdMux[`DTSC_CTRL_ARM_BIT] = arm_reg;
    end else if (isAddr(paddr, `DTSC_OFF_TRIG)) begin
      rdMux[`DTSC_TRIG_OPQ_BIT] = opqSel_reg;
      rdMux[`DTSC_TRIG_BEG_BIT] = beginSel_reg;
      rdMux[`DTSC_TRIG_MODE_HI:0] = mode_reg;
    end else if (isAddr(paddr, `DTSC_OFF_STAT)) begin
      rdMux[`DTSC_STAT_AF_BIT]  = aFlag_reg;
      rdMux[`DTSC_STAT_BF_BIT]  = bFlag_reg;
      rdMux[`DTSC_STAT_ARM_BIT] = enable_reg & arm_reg;
      rdMux[3:0]                = count_reg;
    end else if (isAddr(paddr, `DTSC_OFF_FIFO)) begin
      rdMux[15:0] = memRdData;
    end
  end

  // apb answer: data and ready latched in setup, one access cycle
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase & ~mapped;
      if (setupPhase & ~pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  // security level synchroniser
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      secureMeta_reg <= 1'b1;
      secure_reg     <= 1'b1;
    end else begin
      secureMeta_reg <= secure;
      secure_reg     <= secureMeta_reg;
    end
  end

  // control register: enable and arm
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= CTRL_RST[`DTSC_CTRL_EN_BIT];
      arm_reg    <= CTRL_RST[`DTSC_CTRL_ARM_BIT];
    end else begin
      if (ctrlWr) begin
        enable_reg <= wrEnable;
      end
      if (startRun) begin
        arm_reg <= 1'b1;
      end else if (stopRun | runDone) begin
        arm_reg <= 1'b0;
      end
    end
  end

  // trigger configuration, written only while unarmed
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      opqSel_reg   <= TRIG_RST[`DTSC_TRIG_OPQ_BIT];
      beginSel_reg <= TRIG_RST[`DTSC_TRIG_BEG_BIT];
      mode_reg     <= TRIG_RST[`DTSC_TRIG_MODE_HI:0];
    end else if (wrAcc & isAddr(paddr, `DTSC_OFF_TRIG) & ~arm_reg) begin
      opqSel_reg   <= pwdata[`DTSC_TRIG_OPQ_BIT];
      beginSel_reg <= pwdata[`DTSC_TRIG_BEG_BIT];
      mode_reg     <= pwdata[`DTSC_TRIG_MODE_HI:0];
    end
  end

  // match flags: cleared at run start, set wins while armed
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aFlag_reg <= 1'b0;
      bFlag_reg <= 1'b0;
    end else begin
      if (arm_reg & aHit) begin
        aFlag_reg <= 1'b1;
      end else if (startRun) begin
        aFlag_reg <= 1'b0;
      end
      if (arm_reg & bHit) begin
        bFlag_reg <= 1'b1;
      end else if (startRun) begin
        bFlag_reg <= 1'b0;
      end
    end
  end

  // sequencing: a-then-b memory and opcode tag tracking
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seqA_reg       <= 1'b0;
      tagPending_reg <= 1'b0;
      storing_reg    <= 1'b0;
    end else if (startRun) begin
      seqA_reg       <= 1'b0;
      tagPending_reg <= 1'b0;
      storing_reg    <= 1'b0;
    end else if (arm_reg) begin
      if (aHit) begin
        seqA_reg <= 1'b1;
      end
      if (opqSel_reg & opcodeFetch) begin
        tagPending_reg <= rawTrig;
      end else if (opcodeExecute) begin
        tagPending_reg <= 1'b0;
      end
      if (trigNow & beginTrace) begin
        storing_reg <= 1'b1;
      end
    end
  end

  // write pointer, valid count and read pointer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg <= {FIFO_AW{1'b0}};
      rdPtr_reg <= {FIFO_AW{1'b0}};
      count_reg <= `DTSC_CNT_RST;
    end else begin
      rdPtr_reg <= rdPtr_next;
      if (startRun) begin
        wrPtr_reg <= {FIFO_AW{1'b0}};
        count_reg <= `DTSC_CNT_RST;
      end else if (storeNow) begin
        wrPtr_reg <= wrPtrInc;
        if (count_reg != `DTSC_FIFO_WORDS) begin
          count_reg <= count_reg + 4'h1;
        end
      end
    end
  end

  // trace word storage
  dtsc_trace_mem #(
    .WIDTH (16),
    .DEPTH (1 << FIFO_AW),
    .AW    (FIFO_AW)
  ) traceMem (
    .clock  (clock),
    .resetn (resetn),
    .wrEn   (storeNow),
    .wrAddr (wrPtr_reg),
    .wrData (storeWord),
    .rdAddr (rdPtr_next),
    .rdData (memRdData)
  );

endmodule

//--- sim/dtsc_cpu_model.sv
// Purpose: cpu bus and comparator side of the trace trigger block
// Assumes: the bench calls its tasks; one access per call
// Notes:   address and data show an inverted pattern between accesses
module dtsc_cpu_model (
  // clock
  input  wire logic clock,
  // bus access and comparator results
  output logic        busCycle,
  output logic [15:0] busAddr,
  output logic [7:0]  busData,
  output logic        cmpAMatch,
  output logic        cmpBMatch,
  output logic        cmpBDataMatch,
  output logic        addrGeA,
  output logic        addrLeB,
  output logic        opcodeFetch,
  output logic        opcodeExecute
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {busCycle, opcodeFetch, opcodeExecute, busAddr, busData} = 27'h0;
    {cmpAMatch, cmpBMatch, cmpBDataMatch, addrGeA, addrLeB} = 5'h0;
  end
  // one fetch access held for a clock, then gap idle clocks
  task automatic access(input logic [15:0] a, input logic [7:0] d, input logic [4:0] h,
                        input int gap);
    @(posedge clock);
    {busCycle, opcodeFetch} <= 2'h3;
    {busAddr, busData} <= {a, d};
    {cmpAMatch, cmpBMatch, cmpBDataMatch, addrGeA, addrLeB} <= h;
    @(posedge clock);
    {busCycle, opcodeFetch} <= 2'h0;
    {busAddr, busData} <= ~{a, d};
    {cmpAMatch, cmpBMatch, cmpBDataMatch, addrGeA, addrLeB} <= 5'h0;
    repeat (gap) @(posedge clock);
  endtask
  // the tagged opcode executes
  task automatic execute();
    @(posedge clock);
    opcodeExecute <= 1'h1;
    @(posedge clock);
    opcodeExecute <= 1'h0;
  endtask
endmodule

//--- sim/dtsc_trigger_status_checker.sv
// Purpose: port assertions for the trace trigger block
// Assumes: bound to dtsc_trigger_status
// Notes:   helpers claim only what the apb write history proves
`include "dtsc_defs.vh"
module dtsc_trigger_status_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // cpu side and security
  input wire logic        busCycle,
  input wire logic        opcodeExecute,
  input wire logic        secure
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // decoded bus phases
  wire logic setup  = psel && !penable;
  wire logic acc    = psel && penable && pready;
  wire logic rdStat = setup && !pwrite && paddr == `DTSC_OFF_STAT;
  wire logic rdTrig = setup && !pwrite && paddr == `DTSC_OFF_TRIG;
  wire logic wrCtrl = acc && pwrite && paddr == `DTSC_OFF_CTRL;
  wire logic wrTrig = acc && pwrite && paddr == `DTSC_OFF_TRIG;
  logic       stopped, justArmed, trigValid, cntValid;
  logic [7:0] trigShadow;
  logic [3:0] lastCnt;
  // run state and register shadows known from the writes
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {stopped, trigValid, justArmed, cntValid} <= 4'hc;
      {trigShadow, lastCnt} <= 12'h000;
    end else begin
      if (wrCtrl) stopped <= !(pwdata[7] && pwdata[6]) || secure;
      if (wrCtrl) justArmed <= pwdata[7] && pwdata[6] && stopped && !secure;
      else if (busCycle || opcodeExecute) justArmed <= 1'h0;
      if (wrTrig && stopped) trigShadow <= pwdata[7:0] & 8'hcf;
      if (wrTrig) trigValid <= stopped;
      if (acc && !pwrite && paddr == `DTSC_OFF_STAT) lastCnt <= prdata[3:0];
      if (wrCtrl) cntValid <= 1'h0;
      else if (acc && !pwrite && paddr == `DTSC_OFF_STAT) cntValid <= stopped;
    end
  end
  chk_ready_next: assert property (setup |=> pready)
    else $error("no ready after setup");
  chk_unmapped_err: assert property (setup && paddr > 12'h00c
                                     |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_trig_zero: assert property (rdTrig |=> prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0)
    else $error("trigger reserved bits not zero");
  chk_trig_value: assert property (rdTrig && trigValid |=> prdata[7:0] == trigShadow)
    else $error("trigger register value wrong");
  chk_stop_status: assert property (rdStat && stopped |=> !prdata[5])
    else $error("armed after stop");
  chk_flags_clear: assert property (rdStat && justArmed |=> prdata[7:6] == 2'h0)
    else $error("flags not cleared at run start");
  chk_arm_image: assert property (rdStat && justArmed |=> prdata[5] && prdata[3:0] == 4'h0)
    else $error("arm image or count wrong at run start");
  chk_count_hold: assert property (rdStat && stopped && cntValid |=> prdata[3:0] == lastCnt)
    else $error("valid count changed while stopped");
endmodule

//--- sim/dtsc_trigger_status_test.sv
// Purpose: self-checking bench for the trace trigger and status block
// Assumes: apb master below, cpu side from dtsc_cpu_model
// Notes:   each run is armed from a stopped state
`include "dtsc_defs.vh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module dtsc_trigger_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset, apb and security
  logic        clock = 1'h0;
  logic        resetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        secure = 1'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, busCycle, cmpAMatch, cmpBMatch, cmpBDataMatch;
  wire         addrGeA, addrLeB, opcodeFetch, opcodeExecute;
  wire  [15:0] busAddr;
  wire  [7:0]  busData;
  int          num_errors = 0;
  int          samples_checked = 0;
  localparam logic [11:0] CTRL = `DTSC_OFF_CTRL, TRIG = `DTSC_OFF_TRIG;
  localparam logic [11:0] STAT = `DTSC_OFF_STAT, FIFO = `DTSC_OFF_FIFO;
  // comparator inputs per mode {a, b, b data, ge a, le b} and whether each fires
  localparam logic [79:0] HITS = {{7{5'h1f}}, 5'h03, 5'h03, 5'h14, 5'h14, 5'h10, 5'h10,
                                  5'h08, 5'h08, 5'h10};
  localparam logic [15:0] FIRES = 16'h00a3;
  always #4 clock = ~clock;
  dtsc_trigger_status u_dut (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busCycle(busCycle), .busAddr(busAddr), .busData(busData), .cmpAMatch(cmpAMatch),
    .cmpBMatch(cmpBMatch), .cmpBDataMatch(cmpBDataMatch), .addrGeA(addrGeA),
    .addrLeB(addrLeB), .opcodeFetch(opcodeFetch), .opcodeExecute(opcodeExecute),
    .secure(secure));
  dtsc_cpu_model u_cpu (
    .clock(clock), .busCycle(busCycle), .busAddr(busAddr), .busData(busData),
    .cmpAMatch(cmpAMatch), .cmpBMatch(cmpBMatch), .cmpBDataMatch(cmpBDataMatch),
    .addrGeA(addrGeA), .addrLeB(addrLeB), .opcodeFetch(opcodeFetch),
    .opcodeExecute(opcodeExecute));
  // one apb transfer, held until ready is seen at an edge
  task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                         output logic [31:0] r, output logic e);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apbXfer(1'h1, a, {24'h0, d}, r, e);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apbXfer(1'h0, a, 32'h0, r, e);
    `CHECK(r, x)
    `CHECK(e, 1'h0)
  endtask
  task automatic arm(input logic [7:0] t);
    wr(CTRL, 8'h80);
    wr(TRIG, t);
    wr(CTRL, 8'hc0);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rdChk(CTRL, 32'h0);
    rdChk(STAT, 32'h0);
    apbXfer(1'h0, 12'h010, 32'h0, r, e);
    `CHECK(e, 1'h1)
  endtask
  task automatic t_trig();
    wr(TRIG, 8'hff);
    rdChk(TRIG, 32'hcf);
    arm(8'h00);
    wr(TRIG, 8'h47);
    rdChk(TRIG, 32'h00);
    rdChk(STAT, 32'h20);
    wr(CTRL, 8'h00);
    rdChk(STAT, 32'h00);
    wr(STAT, 8'hff);
    rdChk(STAT, 32'h00);
    wr(TRIG, 8'h47);
    rdChk(TRIG, 32'h47);
  endtask
  task automatic t_end();
    arm(8'h00);
    for (int i = 0; i < 8; i++) u_cpu.access(16'h0100 + 16'(i), 8'h00, 5'h00, i % 2);
    u_cpu.access(16'h0200, 8'h00, 5'h10, 0);
    rdChk(CTRL, 32'h80);
    wr(CTRL, 8'h80);  // already stopped: the count must survive this
    rdChk(STAT, 32'h88);
    for (int n = 1; n <= 8; n++) rdChk(FIFO, (n == 8) ? 32'h200 : 32'h100 + n);
    rdChk(STAT, 32'h88);
  endtask
  task automatic t_begin();
    arm(8'h40);
    rdChk(STAT, 32'h20);
    u_cpu.access(16'h0300, 8'h00, 5'h00, 0);
    for (int i = 0; i < 7; i++) u_cpu.access(16'h0400 + 16'(i), 8'h00, {i == 0, 4'h0}, 0);
    rdChk(CTRL, 32'hc0);
    u_cpu.access(16'h0407, 8'h00, 5'h00, 0);
    rdChk(CTRL, 32'h80);
    rdChk(FIFO, 32'h400);
  endtask
  task automatic t_event();
    arm(8'h03);
    u_cpu.access(16'h0500, 8'h11, 5'h10, 0);
    for (int i = 0; i < 8; i++) u_cpu.access(16'h0600, 8'ha0 + 8'(i), 5'h08, 1);
    rdChk(CTRL, 32'h80);
    rdChk(STAT, 32'hc8);
    rdChk(FIFO, 32'h0a0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      arm(8'(m));
      u_cpu.access(16'h0800, 8'h00, HITS[m*5 +: 5], 1);
      rdChk(CTRL, FIRES[m] ? 32'h80 : 32'hc0);
    end
    // a then b: a alone keeps the run going, a later b ends it
    arm(8'h02);
    u_cpu.access(16'h0800, 8'h00, 5'h10, 1);
    rdChk(CTRL, 32'hc0);
    u_cpu.access(16'h0810, 8'h00, 5'h08, 1);
    rdChk(CTRL, 32'h80);
  endtask
  task automatic t_qualify();
    logic [31:0] r;
    logic        e;
    arm(8'h80);
    u_cpu.access(16'h0900, 8'h00, 5'h10, 1);
    rdChk(CTRL, 32'hc0);
    u_cpu.execute();
    rdChk(CTRL, 32'h80);
    secure <= 1'h1;
    repeat (4) @(posedge clock);
    wr(CTRL, 8'hc0);
    apbXfer(1'h0, CTRL, 32'h0, r, e);
    `CHECK(r[7], 1'h0)
    secure <= 1'h0;
    repeat (4) @(posedge clock);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (6000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
  // reset, then the scenarios
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'h1;
    repeat (3) @(posedge clock);
    t_reset();
    t_trig();
    t_end();
    t_begin();
    t_event();
    t_modes();
    t_qualify();
    report_and_stop();
  end
endmodule
bind dtsc_trigger_status dtsc_trigger_status_checker u_chk (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busCycle(busCycle), .opcodeExecute(opcodeExecute), .secure(secure));
